/* core/vic_pkg.sv */
package vic_pkg;

  // table geometry
  localparam int          VIC_TRAP_SLOTS   = 8;
  localparam int          VIC_IRQ_SLOTS    = 118;
  localparam int          VIC_TABLE_SLOTS  = 126;
  localparam int          VIC_NUM_TRAPS    = 4;
  localparam int          VIC_NUM_IRQS     = 21;
  localparam int          VIC_SLOT_W       = 8;
  localparam int          VIC_ADDR_W       = 24;
  localparam int          VIC_MEM_DEPTH    = 2 * VIC_TABLE_SLOTS;
  localparam int          VIC_MEM_AW       = 8;

  // program memory placement
  localparam logic [23:0] VIC_PRIMARY_BASE = 24'h000004;
  localparam logic [23:0] VIC_RESET_ADDR   = 24'h000000;
  localparam logic [23:0] VIC_ENTRY_STRIDE = 24'h000002;

  // priority encoding
  localparam int          VIC_PRIO_W       = 4;
  localparam logic [3:0]  VIC_PRIO_NONE    = 4'h0;
  localparam logic [3:0]  VIC_PRIO_USR_MAX = 4'h7;
  localparam logic [3:0]  VIC_PRIO_TRAP    = 4'h8;

  // control word bit positions
  localparam int          VIC_ALT_SEL_BIT  = 15;

  // fixed entry and return latencies in cycles
  localparam logic [3:0]  VIC_ENTRY_CYC    = 4'h4;
  localparam logic [3:0]  VIC_RETURN_CYC   = 4'h3;

  // sequencer states
  typedef enum logic [3:0] {
    VIC_IDLE   = 4'h1,
    VIC_FETCH  = 4'h2,
    VIC_ENTRY  = 4'h4,
    VIC_RETURN = 4'h8
  } vic_state_e;

  // vector handed to the core
  typedef struct packed {
    logic [VIC_ADDR_W-1:0] isr_addr;
    logic [VIC_SLOT_W-1:0] slot;
    logic [VIC_PRIO_W-1:0] prio;
  } vic_vector_s;

  // table write port from the program loader
  typedef struct packed {
    logic                  we;
    logic                  alt;
    logic [VIC_SLOT_W-1:0] slot;
    logic [VIC_ADDR_W-1:0] data;
  } vic_tbl_wr_s;

endpackage

/* core/vic_table_mem.sv */
`timescale 1ns/10ps
// both vector tables, alternate stacked after primary
module vic_table_mem
  import vic_pkg::*;
(
  // clock, no reset
  input  wire logic                  ref_clk_i,
  // write side
  input  wire logic                  wr_en_i,
  input  wire logic [VIC_MEM_AW-1:0] wr_idx_i,
  input  wire logic [VIC_ADDR_W-1:0] wr_data_i,
  // read side
  input  wire logic [VIC_MEM_AW-1:0] rd_idx_i,
  output logic      [VIC_ADDR_W-1:0] rd_data_o
);
  logic [VIC_ADDR_W-1:0] mem_q [VIC_MEM_DEPTH];
  logic [VIC_ADDR_W-1:0] rd_q;

  // array write and registered read
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_idx_i] <= wr_data_i;
    end
    rd_q <= mem_q[rd_idx_i];
  end

  assign rd_data_o = rd_q;
endmodule // vic_table_mem

/* core/vic_core.sv */
`timescale 1ns/10ps
module vic_core
  import vic_pkg::*;
(
  // clock and reset
  input  wire logic                                   ref_clk_i,
  input  wire logic                                   nrst_i,
  // sources
  input  wire logic [vic_pkg::VIC_NUM_TRAPS-1:0]      trap_req_i,
  input  wire logic [vic_pkg::VIC_NUM_IRQS-1:0]       irq_req_i,
  input  wire logic [vic_pkg::VIC_NUM_IRQS-1:0]       irq_en_i,
  input  wire logic [vic_pkg::VIC_NUM_IRQS*3-1:0]     irq_prio_i,
  // control word and table loader
  input  wire logic [15:0]                            interrupt_control_reg_two_i,
  input  wire vic_pkg::vic_tbl_wr_s                   tbl_wr_i,
  // core side
  input  wire logic [vic_pkg::VIC_PRIO_W-1:0]         cpu_prio_i,
  input  wire logic                                   cpu_ack_i,
  input  wire logic                                   cpu_ret_i,
  output logic                                        cpu_irq_o,
  output logic                                        vec_valid_o,
  output vic_pkg::vic_vector_s                        vec_o,
  output logic [vic_pkg::VIC_ADDR_W-1:0]              vec_fetch_addr_o,
  output logic [vic_pkg::VIC_ADDR_W-1:0]              reset_pc_o,
  output logic                                        busy_o
);
  import vic_pkg::*;

  // program address of a table slot, either table
  function automatic logic [VIC_ADDR_W-1:0] slot_addr(input logic alt,
                                                      input logic [VIC_SLOT_W-1:0] s);
    logic [VIC_ADDR_W-1:0] idx;
    idx = {{(VIC_ADDR_W-VIC_SLOT_W){1'b0}}, s};
    // alternate table adds one full table of slots
    if (alt) begin
      idx = idx + VIC_ADDR_W'(VIC_TABLE_SLOTS);
    end
    slot_addr = VIC_PRIMARY_BASE + VIC_ENTRY_STRIDE * idx;
  endfunction

  // memory index of a slot, alternate stacked after primary
  function automatic logic [VIC_MEM_AW-1:0] slot_idx(input logic alt,
                                                     input logic [VIC_SLOT_W-1:0] s);
    slot_idx = alt ? VIC_MEM_AW'(s + VIC_SLOT_W'(VIC_TABLE_SLOTS)) : VIC_MEM_AW'(s);
  endfunction

  logic                  alt_table_select;
  logic                  win_vld;
  logic [VIC_SLOT_W-1:0] win_slot;
  logic [VIC_PRIO_W-1:0] win_prio;
  logic [VIC_ADDR_W-1:0] mem_rd;
  vic_state_e            state_q, state_d;
  logic [3:0]            cnt_q, cnt_d;
  vic_vector_s           vec_q, vec_d;
  logic                  irq_q, irq_d;
  logic [VIC_MEM_AW-1:0] rd_idx;
  logic [VIC_MEM_AW-1:0] wr_idx;
  logic                  take_req;
  logic                  ack_taken;
  logic                  cnt_last;

  assign alt_table_select = interrupt_control_reg_two_i[VIC_ALT_SEL_BIT];

  // trap slots first, then interrupt slots, in each table
  // reads follow the latched slot once a request is taken, so the vector
  // cannot drift when the sources drop before the core acknowledges
  assign rd_idx = (state_q == VIC_IDLE) ? slot_idx(alt_table_select, win_slot)
                                        : slot_idx(alt_table_select, vec_q.slot);
  // loader writes alternate entries above the primary ones
  assign wr_idx = slot_idx(tbl_wr_i.alt, tbl_wr_i.slot);

  assign take_req  = win_vld && (win_prio > cpu_prio_i);
  // acknowledge counts only while the request line is up
  assign ack_taken = cpu_ack_i && irq_q;
  // last cycle of a fixed latency
  assign cnt_last  = (cnt_q == 4'h1);

  // arbitration: traps first, then user level, then slot order
  always_comb begin
    logic [VIC_PRIO_W-1:0] p;
    p        = VIC_PRIO_NONE;
    win_vld  = 1'b0;
    win_slot = '0;
    win_prio = VIC_PRIO_NONE;
    // loops run downward, so among equal levels the lowest slot is assigned last and wins
    for (int t = VIC_NUM_TRAPS - 1; t >= 0; t--) begin
      if (trap_req_i[t]) begin
        win_vld  = 1'b1;
        // trap slots sit below the interrupt slots
        win_slot = VIC_SLOT_W'(t);
        win_prio = VIC_PRIO_TRAP;
      end
    end
    // user sources only when no trap is pending
    if (!win_vld) begin
      for (int i = VIC_NUM_IRQS - 1; i >= 0; i--) begin
        p = {1'b0, irq_prio_i[i*3 +: 3]};
        if (irq_req_i[i] && irq_en_i[i] && p != VIC_PRIO_NONE && p >= win_prio) begin
          win_vld  = 1'b1;
          win_slot = VIC_SLOT_W'(VIC_TRAP_SLOTS + i);
          win_prio = p;
        end
      end
    end
  end

  // 24-bit entries, stacked tables
  // registered read: the taken slot's entry appears in the fetch cycle
  vic_table_mem u_mem (
    .ref_clk_i (ref_clk_i),
    .wr_en_i   (tbl_wr_i.we),
    .wr_idx_i  (wr_idx),
    .wr_data_i (tbl_wr_i.data),
    .rd_idx_i  (rd_idx),
    .rd_data_o (mem_rd)
  );

  // sequencer next state
  // a request stands from the fetch until the core takes it; entry and
  // return then run their fixed counts, entry ending early on a return, before new requests are looked at
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    vec_d   = vec_q;
    irq_d   = 1'b0;
    case (state_q)
      VIC_IDLE: begin
        if (take_req) begin
          vec_d.slot = win_slot;
          vec_d.prio = win_prio;
          state_d    = VIC_FETCH;
        end
      end

      VIC_FETCH: begin
        // single request line, dropped on the acknowledge edge
        vec_d.isr_addr = mem_rd;
        irq_d          = !ack_taken;
        if (ack_taken) begin
          cnt_d   = VIC_ENTRY_CYC;
          state_d = VIC_ENTRY;
        end
      end

      VIC_ENTRY: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_last) begin
          state_d = VIC_IDLE;
        end
        // a return from the core cuts the entry short
        if (cpu_ret_i) begin
          cnt_d   = VIC_RETURN_CYC;
          state_d = VIC_RETURN;
        end
      end

      VIC_RETURN: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_last) begin
          state_d = VIC_IDLE;
        end
      end

      default: begin
        state_d = VIC_IDLE;
      end
    endcase
  end

  // reset puts the sequencer in idle and clears the count, vector and request
  // the table memory is not cleared; it keeps what the loader wrote
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= VIC_IDLE;
      cnt_q   <= 4'h0;
      vec_q   <= '0;
      irq_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      vec_q   <= vec_d;
      irq_q   <= irq_d;
    end
  end

  // outputs
  assign cpu_irq_o        = irq_q;
  assign vec_valid_o      = irq_q;  // qualifier mirrors the request
  assign vec_o            = vec_q;
  assign vec_fetch_addr_o = slot_addr(alt_table_select, vec_q.slot);
  assign reset_pc_o       = VIC_RESET_ADDR;
  // busy covers fetch, entry and return
  assign busy_o           = (state_q != VIC_IDLE);
endmodule // vic_core

/* testbench/vic_core_sva.sv */
`timescale 1ns/10ps
// port-level checks on the controller
module vic_core_sva
  import vic_pkg::*;
(
  // clock, reset and core side
  input wire logic        ref_clk_i, nrst_i, cpu_ack_i, cpu_ret_i,
  input wire logic        cpu_irq_o, vec_valid_o, busy_o,
  input wire logic [15:0] interrupt_control_reg_two_i,
  input wire logic [3:0]  cpu_prio_i,
  input wire vic_vector_s vec_o,
  input wire logic [23:0] vec_fetch_addr_o, reset_pc_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_hold; cpu_irq_o && !cpu_ack_i |=> cpu_irq_o && $stable(vec_o); endproperty
  a_hold: assert property (p_hold) else $error("request dropped before ack");
  property p_valid; vec_valid_o == cpu_irq_o; endproperty
  a_valid: assert property (p_valid) else $error("valid differs from request");
  property p_pc; reset_pc_o == 24'h000000; endproperty
  a_pc: assert property (p_pc) else $error("reset address not zero");
  property p_addr;
    cpu_irq_o |-> vec_fetch_addr_o == VIC_PRIMARY_BASE + VIC_ENTRY_STRIDE * ({16'h0000, vec_o.slot}
      + (interrupt_control_reg_two_i[VIC_ALT_SEL_BIT] ? 24'(VIC_TABLE_SLOTS) : 24'h000000));
  endproperty
  a_addr: assert property (p_addr) else $error("wrong entry address");
  property p_prio; $rose(cpu_irq_o) |-> vec_o.prio > cpu_prio_i; endproperty
  a_prio: assert property (p_prio) else $error("winner not above core level");
  property p_trap; cpu_irq_o |-> (vec_o.slot < 8) == (vec_o.prio == VIC_PRIO_TRAP); endproperty
  a_trap: assert property (p_trap) else $error("trap level mismatch");
  property p_busy; cpu_irq_o && cpu_ack_i |=> !cpu_irq_o && busy_o ##1 busy_o[*3]; endproperty
  a_busy: assert property (p_busy) else $error("entry too short");
  property p_idle; cpu_irq_o && cpu_ack_i ##1 !cpu_ret_i[*4] |=> !busy_o; endproperty
  a_idle: assert property (p_idle) else $error("entry too long");
  property p_ret; $past(cpu_ack_i) && $past(cpu_irq_o) && cpu_ret_i |=> busy_o[*3] ##1 !busy_o;
  endproperty
  a_ret: assert property (p_ret) else $error("return length wrong");
  c_ack: cover property (cpu_irq_o && cpu_ack_i);
  c_ret: cover property (cpu_ret_i && busy_o);
  c_alt: cover property (cpu_irq_o && interrupt_control_reg_two_i[15]);
endmodule // vic_core_sva
bind vic_core vic_core_sva u_sva (.ref_clk_i, .nrst_i, .cpu_ack_i, .cpu_ret_i, .cpu_irq_o,
  .vec_valid_o, .busy_o, .interrupt_control_reg_two_i, .cpu_prio_i, .vec_o, .vec_fetch_addr_o,
  .reset_pc_o);

/* testbench/vic_cpu_model.sv */
`timescale 1ns/10ps
// core that accepts after a delay and may return at once
module vic_cpu_model (
  input  wire logic       ref_clk_i, nrst_i, irq_i, ret_en_i,
  input  wire logic [1:0] dly_i,
  output logic            ack_o, ret_o
);
  logic [1:0] cnt_q;
  // ack held until taken, then optional return pulse
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o <= 1'b0;
      ret_o <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      ret_o <= ack_o && irq_i && ret_en_i;
      if (ack_o && irq_i) begin
        ack_o <= 1'b0;
        cnt_q <= 2'h0;
      end else if (irq_i && !ack_o) begin
        cnt_q <= cnt_q + 2'h1;
        ack_o <= (cnt_q == dly_i);
      end
    end
  end
endmodule // vic_cpu_model

/* testbench/vic_core_bench.sv */
`timescale 1ns/10ps
module vic_core_bench;
  import vic_pkg::*;
  typedef struct packed {
    logic [3:0] trap; logic [4:0] a; logic [2:0] la; logic [4:0] b; logic [2:0] lb;
    logic [3:0] cp; logic alt, en; logic [7:0] slot; logic [3:0] pr;
  } vic_row_s;
  logic ref_clk_i = 0, nrst_i = 0, cpu_ack_i, cpu_ret_i, cpu_irq_o, vec_valid_o, busy_o;
  logic [3:0] trap_req_i = 0, cpu_prio_i = 0;
  logic [20:0] irq_req_i = 0, irq_en_i = 0;
  logic [62:0] irq_prio_i = 0;
  logic [15:0] interrupt_control_reg_two_i = 0;
  vic_tbl_wr_s tbl_wr_i = '0;
  vic_vector_s vec_o;
  logic [23:0] vec_fetch_addr_o, reset_pc_o;
  logic [1:0] dly = 0;
  logic ret_en = 0;
  int n_fail = 0, n_checks = 0;
  int w = 0, lat = 0, ofs = 0;
  vic_row_s rows[8] = '{
    '{4'ha, 0, 3, 1, 2, 0, 0, 1, 1, 8}, '{4'h8, 0, 7, 1, 7, 7, 0, 1, 3, 8},
    '{0, 5, 3, 2, 3, 0, 0, 1, 10, 3}, '{0, 0, 2, 5, 6, 1, 0, 1, 13, 6},
    '{0, 20, 7, 19, 1, 0, 1, 1, 28, 7}, '{0, 4, 5, 6, 5, 5, 0, 1, 0, 0},
    '{0, 4, 0, 6, 0, 0, 0, 1, 0, 0}, '{0, 4, 6, 6, 6, 0, 1, 0, 0, 0}};
  vic_core dut_u (.*);
  vic_cpu_model cpu_u (.ref_clk_i, .nrst_i, .irq_i(cpu_irq_o), .ret_en_i(ret_en), .dly_i(dly),
    .ack_o(cpu_ack_i), .ret_o(cpu_ret_i));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  initial begin
    #100000;
    n_fail++;
    finish_test;
  end
  initial begin
    tick(20);
    nrst_i = 1;
    // all slots filled
    // load both tables, alternate stacked after primary
    for (int k = 0; k < 252; k++) begin
      tbl_wr_i = '{1'b1, k >= 126, 8'(k % 126), 24'h400000 + 24'(k)};
      tick(1);
    end
    tbl_wr_i = '0;
    foreach (rows[i]) begin
      irq_req_i = (21'h1 << rows[i].a) | (21'h1 << rows[i].b);
      irq_en_i = rows[i].en ? irq_req_i : 21'h0;
      irq_prio_i = 0;
      irq_prio_i[3*rows[i].a +: 3] = rows[i].la;
      irq_prio_i[3*rows[i].b +: 3] = rows[i].lb;
      trap_req_i = rows[i].trap;
      cpu_prio_i = rows[i].cp;
      interrupt_control_reg_two_i[15] = rows[i].alt;
      {ret_en, dly} = 3'(i);
      for (int k = 0; k < 12 && cpu_irq_o !== 1'b1; k++) tick(1);
      chk("irq", cpu_irq_o, rows[i].pr != 0);
      ofs = rows[i].slot + (rows[i].alt ? VIC_TABLE_SLOTS : 0);
      if (rows[i].pr != 0) begin
        chk("slot", vec_o.slot, rows[i].slot);
        chk("prio", vec_o.prio, rows[i].pr);
        chk("isr", vec_o.isr_addr, 24'h400000 + ofs);
        chk("fadr", vec_fetch_addr_o, VIC_PRIMARY_BASE + VIC_ENTRY_STRIDE * ofs);
      end
      {trap_req_i, irq_req_i} = 0;
      for (w = 0; w < 20 && busy_o !== 1'b0; w++) tick(1);
      chk("busy", busy_o, 0);
      lat = ret_en ? 3 + dly + VIC_RETURN_CYC : 2 + dly + VIC_ENTRY_CYC;
      chk("lat", w, rows[i].pr != 0 ? lat : 0);
    end
    // reset in mid-fetch clears the request, busy and the vector
    trap_req_i = 4'h2;
    tick(2);
    nrst_i = 0;
    #1;
    chk("rst", {cpu_irq_o, busy_o, vec_o, reset_pc_o}, 0);
    trap_req_i = 0;
    tick(2);
    nrst_i = 1;
    tick(3);
    chk("pc", reset_pc_o, 0);
    // table survives reset: a trap after release reads alternate slot 0
    trap_req_i = 4'h1;
    for (int k = 0; k < 12 && cpu_irq_o !== 1'b1; k++) tick(1);
    chk("irq0", cpu_irq_o, 1);
    chk("slot0", vec_o.slot, 0);
    chk("isr0", vec_o.isr_addr, 24'h400000 + VIC_TABLE_SLOTS);
    trap_req_i = 0;
    for (w = 0; w < 20 && busy_o !== 1'b0; w++) tick(1);
    chk("busy0", busy_o, 0);
    finish_test;
  end
endmodule // vic_core_bench
